// File: core/bsf_pkg.sv
package bsf_pkg;
  localparam int DW = 8;
  localparam int AW = 16;
  localparam int OW = 12;
  // status register bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_H = 5;
  // cycle costs
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;
  localparam logic [1:0] CYC_THREE = 2'h3;
  // program counter steps
  localparam logic [AW-1:0] PC_STEP = 16'h0001;
  localparam logic [AW-1:0] PC_SKIP_ONE = 16'h0002;
  localparam logic [AW-1:0] PC_SKIP_TWO = 16'h0003;

  typedef enum logic [4:0] {
    OP_NOP = 5'h00,
    OP_MUL_SIGNED_BY_UNSIGNED = 5'h01,
    OP_FRAC_MUL_UNSIGNED = 5'h02,
    OP_FRAC_MUL_SIGNED = 5'h03,
    OP_FRAC_MUL_SIGNED_BY_UNSIGNED = 5'h04,
    OP_RELATIVE_JUMP = 5'h05,
    OP_RELATIVE_CALL = 5'h06,
    OP_POINTER_JUMP = 5'h07,
    OP_POINTER_CALL = 5'h08,
    OP_COMPARE_SKIP_EQUAL = 5'h09,
    OP_REGISTER_COMPARE = 5'h0a,
    OP_COMPARE_WITH_BORROW = 5'h0b,
    OP_COMPARE_IMMEDIATE = 5'h0c,
    OP_SKIP_REG_BIT_CLEAR = 5'h0d,
    OP_SKIP_REG_BIT_SET = 5'h0e,
    OP_SKIP_IO_BIT_CLEAR = 5'h0f,
    OP_SKIP_IO_BIT_SET = 5'h10,
    OP_BRANCH_FLAG_SET = 5'h11,
    OP_BRANCH_FLAG_CLEAR = 5'h12,
    OP_BRANCH_EQUAL = 5'h13,
    OP_BRANCH_NOT_EQUAL = 5'h14,
    OP_BRANCH_CARRY_SET = 5'h15,
    OP_BRANCH_CARRY_CLEAR = 5'h16,
    OP_BRANCH_SAME_OR_HIGHER = 5'h17,
    OP_BRANCH_LOWER = 5'h18
  } bsf_op_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_EXEC = 2'b10
  } bsf_state_t;

  typedef struct packed {
    bsf_op_t op;
    logic [DW-1:0] rd;
    logic [DW-1:0] rr;
    logic [DW-1:0] io_val;
    logic [2:0] bit_sel;
    logic [OW-1:0] offset;
    logic [AW-1:0] pc;
    logic [AW-1:0] ptr;
    logic [DW-1:0] status_register;
    logic next_two_word;
  } bsf_issue_t;

  typedef struct packed {
    logic pc_load;
    logic [AW-1:0] pc;
    logic status_register_we;
    logic [DW-1:0] status_register;
    logic prod_we;
    logic [AW-1:0] prod;
    logic push;
    logic [AW-1:0] push_addr;
  } bsf_result_t;
endpackage

// File: core/bsf_exec.sv
// Behaviour
// - signed-by-unsigned multiply: product to pair, Z and C, two cycles
// - fractional multiplies shift product left one, Z and C, two cycles
// - relative jump pc+k+1 in two cycles; relative call three cycles
// - pointer jump/call load pc from pointer, two/three cycles, no flags
// - compare-skip-equal skips next instruction when equal, flags untouched
// - compares compute difference unstored, set Z N V C H, one cycle
// - skip when selected register bit is zero
// - skip when selected register bit is one
// - skip when selected io register bit is zero
// - skip when selected io register bit is one
// - branch when selected status bit set; one or two cycles
// - branch when selected status bit clear; one or two cycles, no flags
// - carry-clear and same-or-higher branch on carry zero
// - carry-set and lower branch on carry one
// - branch-equal branches on zero flag one
// - branch-not-equal branches on zero flag zero
`timescale 1ns/100ps
`default_nettype none
module bsf_exec (
  input wire logic CLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic ISSUE_VALID_IN,
  input wire bsf_pkg::bsf_issue_t ISSUE_IN,
  output logic READY_OUT,
  output logic DONE_OUT,
  output bsf_pkg::bsf_result_t RESULT_OUT
);
  import bsf_pkg::*;

  // ----------------------------------------
  // operand decode
  // ----------------------------------------
  bsf_state_t state_q;
  bsf_state_t state_d;
  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  bsf_result_t res_q;
  bsf_result_t res_d;
  logic ready_q;
  logic done_q;
  bsf_result_t out_q;

  wire bsf_op_t op = ISSUE_IN.op;
  wire [DW-1:0] rd = ISSUE_IN.rd;
  wire [DW-1:0] rr = ISSUE_IN.rr;
  wire [DW-1:0] sr = ISSUE_IN.status_register;
  wire [AW-1:0] pc = ISSUE_IN.pc;
  wire fire = ISSUE_VALID_IN && ready_q;

  wire is_mul_signed_by_unsigned = op == OP_MUL_SIGNED_BY_UNSIGNED;
  wire is_fmu = op == OP_FRAC_MUL_UNSIGNED;
  wire is_fms = op == OP_FRAC_MUL_SIGNED;
  wire is_fmsu = op == OP_FRAC_MUL_SIGNED_BY_UNSIGNED;
  wire is_frac = is_fmu || is_fms || is_fmsu;
  wire is_mul = is_mul_signed_by_unsigned || is_frac;
  wire is_relative_call = op == OP_RELATIVE_CALL;
  wire is_rel = op == OP_RELATIVE_JUMP || is_relative_call;
  wire is_pcall = op == OP_POINTER_CALL;
  wire is_ptr = op == OP_POINTER_JUMP || is_pcall;
  wire is_call = is_relative_call || is_pcall;
  wire is_cpc = op == OP_COMPARE_WITH_BORROW;
  wire is_cmp = op == OP_REGISTER_COMPARE || is_cpc
    || op == OP_COMPARE_IMMEDIATE;
  wire is_compare_skip_equal = op == OP_COMPARE_SKIP_EQUAL;
  wire is_sr_clr = op == OP_SKIP_REG_BIT_CLEAR;
  wire is_sr_set = op == OP_SKIP_REG_BIT_SET;
  wire is_si_clr = op == OP_SKIP_IO_BIT_CLEAR;
  wire is_si_set = op == OP_SKIP_IO_BIT_SET;
  wire is_skip = is_compare_skip_equal || is_sr_clr || is_sr_set
    || is_si_clr || is_si_set;
  wire is_bset = op == OP_BRANCH_FLAG_SET;
  wire is_bclr = op == OP_BRANCH_FLAG_CLEAR;
  wire is_beq = op == OP_BRANCH_EQUAL;
  wire is_bne = op == OP_BRANCH_NOT_EQUAL;
  wire is_bcs = op == OP_BRANCH_CARRY_SET
    || op == OP_BRANCH_LOWER;
  wire is_bcc = op == OP_BRANCH_CARRY_CLEAR
    || op == OP_BRANCH_SAME_OR_HIGHER;
  wire is_branch = is_bset || is_bclr || is_beq || is_bne
    || is_bcs || is_bcc;

  // ----------------------------------------
  // multiplier
  // ----------------------------------------
  // rd signed except for unsigned fractional; rr signed only for signed frac
  wire rd_signed = is_mul_signed_by_unsigned || is_fms || is_fmsu;
  wire rr_signed = is_fms;
  wire [AW-1:0] a16 = {{DW{rd_signed && rd[DW-1]}}, rd};
  wire [AW-1:0] b16 = {{DW{rr_signed && rr[DW-1]}}, rr};
  wire [AW-1:0] raw_p = AW'(a16 * b16);
  wire [AW-1:0] prod = is_frac ? {raw_p[AW-2:0], 1'b0} : raw_p;
  wire mul_c = raw_p[AW-1];
  wire mul_z = prod == '0;

  // ----------------------------------------
  // comparator
  // ----------------------------------------
  wire cin = is_cpc && sr[FLAG_C];
  wire [DW:0] diff = {1'b0, rd} - {1'b0, rr} - {{DW{1'b0}}, cin};
  wire [DW-1:0] r = diff[DW-1:0];
  wire cmp_c = diff[DW];
  // half carry comes from the top bit of the low nibble
  localparam int HALF_MSB = DW / 2 - 1;
  wire cmp_h = (~rd[HALF_MSB] & rr[HALF_MSB]) | (rr[HALF_MSB] & r[HALF_MSB])
    | (r[HALF_MSB] & ~rd[HALF_MSB]);
  wire cmp_v = (rd[DW-1] & ~rr[DW-1] & ~r[DW-1]) | (~rd[DW-1] & rr[DW-1] & r[DW-1]);
  wire cmp_n = r[DW-1];
  // borrow form keeps zero only if it was already set
  wire cmp_z = (r == '0) && (!is_cpc || sr[FLAG_Z]);

  // ----------------------------------------
  // skip and branch conditions
  // ----------------------------------------
  wire reg_bit = rr[ISSUE_IN.bit_sel];
  wire io_bit = ISSUE_IN.io_val[ISSUE_IN.bit_sel];
  wire sel_flag = sr[ISSUE_IN.bit_sel];
  wire skip_eq = is_compare_skip_equal && rd == rr;
  wire skip_rc = is_sr_clr && !reg_bit;
  wire skip_rs = is_sr_set && reg_bit;
  wire skip_ic = is_si_clr && !io_bit;
  wire skip_is = is_si_set && io_bit;
  wire do_skip = skip_eq || skip_rc || skip_rs || skip_ic || skip_is;
  wire tk_set = is_bset && sel_flag;
  wire tk_clr = is_bclr && !sel_flag;
  wire tk_cc = is_bcc && !sr[FLAG_C];
  wire tk_cs = is_bcs && sr[FLAG_C];
  wire tk_eq = is_beq && sr[FLAG_Z];
  wire tk_ne = is_bne && !sr[FLAG_Z];
  wire taken = tk_set || tk_clr || tk_cc || tk_cs || tk_eq || tk_ne;

  // ----------------------------------------
  // targets and cycle cost
  // ----------------------------------------
  wire [AW-1:0] off16 = {{(AW-OW){ISSUE_IN.offset[OW-1]}}, ISSUE_IN.offset};
  wire [AW-1:0] pc_next = pc + PC_STEP;
  wire [AW-1:0] tgt_rel = pc_next + off16;
  wire [AW-1:0] skip_pc = pc + (ISSUE_IN.next_two_word ? PC_SKIP_TWO : PC_SKIP_ONE);
  wire [AW-1:0] new_pc = (is_rel || taken) ? tgt_rel
    : is_ptr ? ISSUE_IN.ptr
    : do_skip ? skip_pc : pc_next;
  wire [1:0] skip_cyc = ISSUE_IN.next_two_word ? CYC_THREE : CYC_TWO;
  wire [1:0] cyc = is_call ? CYC_THREE
    : (is_mul || is_rel || is_ptr || taken) ? CYC_TWO
    : do_skip ? skip_cyc : CYC_ONE;

  // ----------------------------------------
  // result assembly
  // ----------------------------------------
  logic [DW-1:0] sr_new;
  always_comb
  begin
    sr_new = sr;
    if (is_mul)
    begin
      sr_new[FLAG_Z] = mul_z;
      sr_new[FLAG_C] = mul_c;
    end
    else if (is_cmp)
    begin
      sr_new[FLAG_Z] = cmp_z;
      sr_new[FLAG_C] = cmp_c;
      sr_new[FLAG_N] = cmp_n;
      sr_new[FLAG_V] = cmp_v;
      sr_new[FLAG_H] = cmp_h;
    end
  end

  always_comb
  begin
    res_d = res_q;
    if (fire)
    begin
      res_d.pc_load = 1'b1;
      res_d.pc = new_pc;
      res_d.status_register_we = is_mul || is_cmp;
      res_d.status_register = sr_new;
      res_d.prod_we = is_mul;
      res_d.prod = prod;
      res_d.push = is_call;
      res_d.push_addr = pc_next;
    end
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  wire last = state_q == ST_EXEC && cnt_q == 2'h0;

  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    unique case (state_q)
      ST_IDLE:
      begin
        if (fire)
        begin
          state_d = ST_EXEC;
          cnt_d = cyc - CYC_ONE;
        end
      end
      ST_EXEC:
      begin
        if (cnt_q == 2'h0)
          state_d = ST_IDLE;
        else
          cnt_d = cnt_q - 2'h1;
      end
      default:
      begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_IN)
  begin
    if (SYS_RST_IN)
    begin
      state_q <= ST_IDLE;
      cnt_q <= 2'h0;
      res_q <= '0;
      ready_q <= 1'b1;
      done_q <= 1'b0;
      out_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      res_q <= res_d;
      ready_q <= state_d == ST_IDLE;
      done_q <= last;
      out_q <= last ? res_q : '0;
    end
  end

  assign READY_OUT = ready_q;
  assign DONE_OUT = done_q;
  assign RESULT_OUT = out_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (SYS_RST_IN);

  a_mul_product: assert property (
    fire && is_mul_signed_by_unsigned |-> ##3 DONE_OUT && RESULT_OUT.prod_we
      && RESULT_OUT.prod == $past(raw_p, 3))
    else $error("signed-by-unsigned product wrong or late");

  a_frac_shift: assert property (
    fire && is_frac |-> ##3 DONE_OUT
      && RESULT_OUT.prod == {$past(raw_p[AW-2:0], 3), 1'b0}
      && RESULT_OUT.status_register[FLAG_C] == $past(raw_p[AW-1], 3))
    else $error("fractional product not shifted");

  a_rel_jump: assert property (
    fire && op == OP_RELATIVE_JUMP |=> !DONE_OUT[*2] ##1 DONE_OUT
      && RESULT_OUT.pc == $past(tgt_rel, 3))
    else $error("relative jump target or timing wrong");

  a_ptr_call: assert property (
    fire && is_pcall |-> ##4 DONE_OUT && !RESULT_OUT.status_register_we
      && RESULT_OUT.pc == $past(ISSUE_IN.ptr, 4))
    else $error("pointer call target wrong");

  a_cmp_flags: assert property (
    fire && is_cmp |=> ##1 DONE_OUT && RESULT_OUT.status_register_we
      && RESULT_OUT.status_register[FLAG_C] == $past(cmp_c, 2))
    else $error("compare flags not in one cycle");

  a_skip_two_word: assert property (
    fire && do_skip && ISSUE_IN.next_two_word
      |-> ##4 DONE_OUT && RESULT_OUT.pc == $past(pc, 4) + PC_SKIP_TWO)
    else $error("two-word skip wrong");

  a_branch_taken: assert property (
    fire && tk_eq |-> ##3 DONE_OUT && RESULT_OUT.pc == $past(tgt_rel, 3))
    else $error("taken branch wrong");

  a_branch_idle: assert property (
    fire && is_bcc && sr[FLAG_C] |-> ##2 DONE_OUT
      && RESULT_OUT.pc == $past(pc_next, 2) && !RESULT_OUT.status_register_we)
    else $error("untaken carry branch wrong");

  a_call_push: assert property (
    fire && is_call |-> ##4 RESULT_OUT.push
      && RESULT_OUT.push_addr == $past(pc_next, 4))
    else $error("call did not push return address");

  a_skip_one_word: assert property (
    fire && do_skip && !ISSUE_IN.next_two_word |-> ##3 DONE_OUT
      && RESULT_OUT.pc == $past(pc, 3) + PC_SKIP_ONE && !RESULT_OUT.status_register_we)
    else $error("one-word skip wrong");

  a_skip_not_taken: assert property (
    fire && is_skip && !do_skip |-> ##2 DONE_OUT && RESULT_OUT.pc == $past(pc_next, 2))
    else $error("unskipped instruction wrong");

  a_rel_call: assert property (
    fire && is_relative_call |-> ##4 DONE_OUT && RESULT_OUT.pc == $past(tgt_rel, 4))
    else $error("relative call target or timing wrong");

  a_flag_clear: assert property (
    fire && tk_clr |-> ##3 DONE_OUT && !RESULT_OUT.status_register_we
      && RESULT_OUT.pc == $past(tgt_rel, 3))
    else $error("flag-clear branch wrong");

  a_carry_set: assert property (
    fire && tk_cs |-> ##3 DONE_OUT && RESULT_OUT.pc == $past(tgt_rel, 3))
    else $error("carry-set branch wrong");

  c_frac: cover property (fire && is_frac ##3 DONE_OUT);
  c_cmp: cover property (fire && is_cmp ##2 DONE_OUT);
  c_skip3: cover property (fire && do_skip && ISSUE_IN.next_two_word);
  c_relative_call: cover property (fire && is_relative_call ##4 RESULT_OUT.push);
  c_taken: cover property (fire && taken);
endmodule
`default_nettype wire

// File: testbench/branch_skip_fracmul_exec_tb.sv
`timescale 1ns/100ps
`default_nettype none
module branch_skip_fracmul_exec_tb;
  import bsf_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic issue_valid = 1'b0;
  bsf_issue_t issue = '0;
  logic ready;
  logic done;
  bsf_result_t res;
  int num_errors = 0;
  int samples_checked = 0;
  int cycles = 0;

  always #2.5 clk = ~clk;

  bsf_exec uut (
    .CLK_IN(clk),
    .SYS_RST_IN(rst),
    .ISSUE_VALID_IN(issue_valid),
    .ISSUE_IN(issue),
    .READY_OUT(ready),
    .DONE_OUT(done),
    .RESULT_OUT(res)
  );

  task automatic close_out();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // a hang ends the run well past the few hundred cycles needed
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      num_errors++;
      close_out();
    end
  end

  // ----
  // stimulus helpers
  // ----
  function automatic bsf_issue_t mk(input bsf_op_t op, input logic [7:0] rd, rr, io,
    input logic [2:0] b, input logic [11:0] k, input logic [15:0] pc, ptr,
    input logic [7:0] sr, input logic tw);
    mk = '0;
    mk.op = op;
    mk.rd = rd;
    mk.rr = rr;
    mk.io_val = io;
    mk.bit_sel = b;
    mk.offset = k;
    mk.pc = pc;
    mk.ptr = ptr;
    mk.status_register = sr;
    mk.next_two_word = tw;
  endfunction

  // issue one request, count cycles to the done pulse and judge it
  task automatic run(input bsf_issue_t is, input logic [1:0] c, input logic [15:0] pc,
    input logic fw, input logic [7:0] sr, input logic pw, input logic [15:0] pr,
    input logic pu);
    int n;
    logic bad;
    @(negedge clk);
    issue_valid = 1'b1;
    issue = is;
    @(negedge clk);
    issue_valid = 1'b0;
    n = 0;
    bad = 1'b0;
    while (done !== 1'b1 && n < 6)
    begin
      bad |= (ready !== 1'b0) || (res !== '0);
      @(negedge clk);
      n++;
    end
    samples_checked++;
    bad |= (n != c) || (ready !== 1'b1) || (res.pc_load !== 1'b1) || (res.pc !== pc);
    bad |= (res.prod_we !== pw) || (res.push !== pu);
    bad |= pw && (res.prod !== pr);
    bad |= pu && (res.push_addr !== is.pc + PC_STEP);
    bad |= fw ? (res.status_register_we !== 1'b1 || res.status_register !== sr)
              : (res.status_register_we !== 1'b0 || res.status_register !== sr);
    if (bad)
    begin
      num_errors++;
      $display("Error at %0t: op %0d took %0d cycles, pc %h", $time, is.op, n, res.pc);
    end
  endtask

  // ----
  // scenarios
  // ----
  task automatic t_mul();
    bsf_op_t ops [4] = '{OP_MUL_SIGNED_BY_UNSIGNED, OP_FRAC_MUL_UNSIGNED,
                         OP_FRAC_MUL_SIGNED, OP_FRAC_MUL_SIGNED_BY_UNSIGNED};
    logic [7:0] rds [3] = '{8'h80, 8'h00, 8'h80};
    logic [7:0] rrs [3] = '{8'hff, 8'hff, 8'h80};
    logic [15:0] a, b, p, s;
    logic [7:0] e;
    for (int i = 0; i < 12; i++)
    begin
      a = (ops[i%4] == OP_FRAC_MUL_UNSIGNED) ? {8'h00, rds[i/4]} : {{8{rds[i/4][7]}}, rds[i/4]};
      b = (ops[i%4] == OP_FRAC_MUL_SIGNED) ? {{8{rrs[i/4][7]}}, rrs[i/4]} : {8'h00, rrs[i/4]};
      p = a * b;
      s = (ops[i%4] == OP_MUL_SIGNED_BY_UNSIGNED) ? p : p << 1;
      e = 8'ha4;
      e[FLAG_C] = p[15];
      e[FLAG_Z] = (s == 16'h0000);
      run(mk(ops[i%4], rds[i/4], rrs[i/4], 8'h00, 3'h0, 12'h000, 16'h0040, 16'h0000, 8'ha4,
        1'b0), CYC_TWO, 16'h0041, 1'b1, e, 1'b1, s, 1'b0);
    end
    $display("t_mul finished");
  endtask

  task automatic t_jump();
    run(mk(OP_RELATIVE_JUMP, 8'h00, 8'h00, 8'h00, 3'h0, 12'h800, 16'h1000, 16'h0000, 8'h5a,
      1'b0), CYC_TWO, 16'h0801, 1'b0, 8'h5a, 1'b0, 16'h0000, 1'b0);
    run(mk(OP_RELATIVE_CALL, 8'h00, 8'h00, 8'h00, 3'h0, 12'h7ff, 16'h1000, 16'h0000, 8'h5a,
      1'b0), CYC_THREE, 16'h1800, 1'b0, 8'h5a, 1'b0, 16'h0000, 1'b1);
    run(mk(OP_POINTER_JUMP, 8'h00, 8'h00, 8'h00, 3'h0, 12'h005, 16'h1000, 16'hbeef, 8'h5a,
      1'b0), CYC_TWO, 16'hbeef, 1'b0, 8'h5a, 1'b0, 16'h0000, 1'b0);
    run(mk(OP_POINTER_CALL, 8'h00, 8'h00, 8'h00, 3'h0, 12'h005, 16'h2222, 16'h4321, 8'h5a,
      1'b0), CYC_THREE, 16'h4321, 1'b0, 8'h5a, 1'b0, 16'h0000, 1'b1);
    $display("t_jump finished");
  endtask

  task automatic t_skip();
    bsf_op_t ops [5] = '{OP_COMPARE_SKIP_EQUAL, OP_SKIP_REG_BIT_CLEAR, OP_SKIP_REG_BIT_SET,
                         OP_SKIP_IO_BIT_CLEAR, OP_SKIP_IO_BIT_SET};
    logic [2:0] b;
    logic [7:0] m, v;
    logic io, cnd;
    for (int i = 0; i < 20; i++)
    begin
      b = 3'(i / 4 + 2);
      m = 8'h01 << b;
      v = i[0] ? ~m : m;
      io = (ops[i/4] == OP_SKIP_IO_BIT_CLEAR) || (ops[i/4] == OP_SKIP_IO_BIT_SET);
      case (ops[i/4])
        OP_COMPARE_SKIP_EQUAL: cnd = !i[0];
        OP_SKIP_REG_BIT_CLEAR, OP_SKIP_IO_BIT_CLEAR: cnd = i[0];
        default: cnd = !i[0];
      endcase
      run(mk(ops[i/4], m, io ? ~v : v, io ? v : ~v, b, 12'h000, 16'hfffe, 16'h0000, 8'h3c,
        i[1]), cnd ? (i[1] ? CYC_THREE : CYC_TWO) : CYC_ONE,
        16'hfffe + (cnd ? (i[1] ? PC_SKIP_TWO : PC_SKIP_ONE) : PC_STEP), 1'b0, 8'h3c,
        1'b0, 16'h0000, 1'b0);
    end
    $display("t_skip finished");
  endtask

  function automatic logic [7:0] cmpf(input logic [7:0] a, b, sr, input logic wc);
    logic [7:0] r;
    cmpf = sr;
    r = a - b - (wc & sr[FLAG_C]);
    cmpf[FLAG_H] = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
    cmpf[FLAG_V] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
    cmpf[FLAG_N] = r[7];
    cmpf[FLAG_C] = (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]);
    cmpf[FLAG_Z] = (r == 8'h00) & (!wc | sr[FLAG_Z]);
  endfunction

  task automatic t_cmp();
    bsf_op_t ops [3] = '{OP_REGISTER_COMPARE, OP_COMPARE_WITH_BORROW, OP_COMPARE_IMMEDIATE};
    logic [7:0] rds [4] = '{8'h10, 8'h80, 8'h01, 8'h33};
    logic [7:0] rrs [4] = '{8'h01, 8'h01, 8'h02, 8'h33};
    logic [7:0] sr;
    for (int i = 0; i < 24; i++)
    begin
      sr = i[0] ? 8'h03 : 8'h00;
      run(mk(ops[i%3], rds[i/6], rrs[i/6], 8'h00, 3'h0, 12'h000, 16'h0300, 16'h0000, sr, 1'b0),
        CYC_ONE, 16'h0301, 1'b1, cmpf(rds[i/6], rrs[i/6], sr, ops[i%3] == OP_COMPARE_WITH_BORROW),
        1'b0, 16'h0000, 1'b0);
    end
    $display("t_cmp finished");
  endtask

  // a call cut by reset in mid-flight must leave no done pulse behind
  task automatic t_reset();
    @(negedge clk);
    issue_valid = 1'b1;
    issue = mk(OP_POINTER_CALL, 8'h00, 8'h00, 8'h00, 3'h0, 12'h000, 16'h0010, 16'h0020, 8'h00,
      1'b0);
    @(negedge clk);
    issue_valid = 1'b0;
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    for (int i = 0; i < 5; i++)
    begin
      samples_checked++;
      if (ready !== 1'b1 || done !== 1'b0 || res !== '0)
      begin
        num_errors++;
        $display("Error at %0t: outputs not idle after mid-run reset", $time);
      end
      @(negedge clk);
    end
    $display("t_reset finished");
  endtask

  task automatic t_branch();
    bsf_op_t ops [8] = '{OP_BRANCH_FLAG_SET, OP_BRANCH_FLAG_CLEAR, OP_BRANCH_EQUAL,
                         OP_BRANCH_NOT_EQUAL, OP_BRANCH_CARRY_SET, OP_BRANCH_LOWER,
                         OP_BRANCH_CARRY_CLEAR, OP_BRANCH_SAME_OR_HIGHER};
    logic [7:0] srs [6] = '{8'h00, 8'hff, 8'h01, 8'h02, 8'h55, 8'haa};
    logic [2:0] b;
    logic cnd;
    for (int i = 0; i < 48; i++)
    begin
      b = 3'(i / 8 * 3 + i);
      case (ops[i%8])
        OP_BRANCH_FLAG_SET: cnd = srs[i/8][b];
        OP_BRANCH_FLAG_CLEAR: cnd = !srs[i/8][b];
        OP_BRANCH_EQUAL: cnd = srs[i/8][FLAG_Z];
        OP_BRANCH_NOT_EQUAL: cnd = !srs[i/8][FLAG_Z];
        OP_BRANCH_CARRY_SET, OP_BRANCH_LOWER: cnd = srs[i/8][FLAG_C];
        default: cnd = !srs[i/8][FLAG_C];
      endcase
      run(mk(ops[i%8], 8'h00, 8'h00, 8'h00, b, 12'hffe, 16'h0100, 16'h0000, srs[i/8], 1'b0),
        cnd ? CYC_TWO : CYC_ONE, cnd ? 16'h00ff : 16'h0101, 1'b0, srs[i/8], 1'b0, 16'h0000,
        1'b0);
    end
    $display("t_branch finished");
  endtask

  initial
  begin
    repeat (20) @(negedge clk);
    rst = 1'b0;
    samples_checked++;
    if (ready !== 1'b1 || done !== 1'b0 || res !== '0)
    begin
      num_errors++;
      $display("Error at %0t: outputs not idle after reset", $time);
    end
    t_mul();
    t_jump();
    t_reset();
    t_skip();
    t_cmp();
    t_branch();
    close_out();
  end
endmodule
`default_nettype wire
